// ===== smmd_cpu_model.sv
// behavioural cpu core issuing fetches and data accesses
`timescale 1ns/1ns
module smmd_cpu_model (
	// clock
	input wire logic aclk,
	// requests
	output logic fetch_req = 1'b0,
	output logic [15:0] fetch_pc = 16'h0000,
	output logic fetch_vector = 1'b0,
	output logic data_req = 1'b0,
	output logic data_write = 1'b0,
	output logic [15:0] instruction_address_operand = 16'h0000
);
	// one fetch, then release with an inverted pc
	task fetch(input logic [15:0] pc, input logic vec);
		@(posedge aclk);
		fetch_req <= 1'b1;
		fetch_pc <= pc;
		fetch_vector <= vec;
		@(posedge aclk);
		fetch_req <= 1'b0;
		fetch_vector <= 1'b0;
		fetch_pc <= ~pc;
	endtask
	// one byte access, then release with an inverted offset
	task access(input logic [15:0] ofs, input logic wr);
		@(posedge aclk);
		data_req <= 1'b1;
		data_write <= wr;
		instruction_address_operand <= ofs;
		@(posedge aclk);
		data_req <= 1'b0;
		data_write <= ~wr;
		instruction_address_operand <= ~ofs;
	endtask
endmodule

// ===== smmd_decoder.sv
// segmented memory map decoder with axi4-lite register slave
`timescale 1ns/1ns
// What this block does
// - program and data spaces are divided into 64 Kbyte segments.
// - program address is code segment (4 bits) above program counter (16 bits).
// - top code segment bit ignored; values eight to fifteen alias zero to seven.
// - data address is data segment (5 bits) above instruction address (16 bits).
// - each data location is one byte; transfers move 8-bit units.
// - rom window in data segment zero reads program segment zero, ignoring segment register.
// - program segment zero and data segment zero are separate spaces.
// - data segments one to seven mirror program segments one to seven.
// - data segments eight to fifteen mirror program segments zero to seven.
// - mirror segments reach every offset of program segments zero to seven.
// - data segment thirty-one is the data flash region.
// - data space holds a one-kilobyte test region.
// - reset and interrupt vectors are fetched from the program vector table; vector fetches here keep the code segment and reach it only in segment zero.
// - 64-byte option region selects mode, pll, watchdog, unused reset, remap.
// - flash remap address reset value comes from option settings.
// - ram contents are not cleared by hardware after reset.
module smmd_decoder
	import smmd_pkg::*;
#(
	parameter int ADDR_W = 18
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// option settings
	input wire logic [7:0] opt_remap_default,
	// cpu program fetch
	input wire logic fetch_req,
	input wire logic [15:0] fetch_pc,
	input wire logic fetch_vector,
	// cpu data access
	input wire logic data_req,
	input wire logic data_write,
	input wire logic [15:0] instruction_address_operand,
	// decoded program side
	output logic [19:0] prog_addr,
	output logic prog_fetch_en,
	output logic vector_table_hit,
	output logic option_region_hit,
	// decoded data side
	output logic [20:0] data_addr,
	output logic [19:0] data_prog_addr,
	output logic data_byte_en,
	output logic sel_ram,
	output logic sel_special_function_register,
	output logic sel_romwin,
	output logic sel_mirror,
	output logic sel_test,
	output logic sel_dflash,
	output logic data_unmapped,
	// register values
	output logic [7:0] flash_remap_address,
	// axi4-lite write address
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// axi4-lite write data
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// axi4-lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read address
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// axi4-lite read data
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);

	if (ADDR_W < 18) begin : g_chk
		$error("ADDR_W must be at least 18");
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	logic [7:0] data_segment_select;
	logic [7:0] reserved_slot_a4;
	logic [7:0] reserved_slot_a6;
	logic [3:0] code_segment_select;
	logic remap_loaded;
	logic [7:0] status;

	// ----------------------------------------
	// program address formation
	// ----------------------------------------
	wire [2:0] cseg_eff = code_segment_select[2:0];
	wire [19:0] next_prog_addr = {1'b0, cseg_eff, fetch_pc};
	wire next_vec_hit = fetch_req && fetch_vector && (next_prog_addr <= SMMD_VEC_LAST);
	wire next_copt_hit = fetch_req && (next_prog_addr >= SMMD_COPT_FIRST)
		&& (next_prog_addr <= SMMD_COPT_LAST);
	// option region is never executed; the fetch is withheld
	wire next_fetch_en = fetch_req && !next_copt_hit;

	// ----------------------------------------
	// data address formation and region decode
	// ----------------------------------------
	wire [4:0] dseg = data_segment_select[4:0];
	wire [15:0] dofs = instruction_address_operand;
	wire [20:0] next_data_addr = {dseg, dofs};
	wire seg0 = (dseg == SMMD_SEG_ZERO);
	wire d_romwin = seg0 && (dofs <= SMMD_ROMWIN_LAST) && !data_write;
	wire d_ram = seg0 && (dofs >= SMMD_RAM_FIRST) && (dofs <= SMMD_RAM_LAST);
	wire d_test = seg0 && (dofs >= SMMD_TEST_FIRST) && (dofs <= SMMD_TEST_LAST);
	wire d_sfr = seg0 && (dofs >= SMMD_SFR_FIRST) && (dofs <= SMMD_SFR_LAST);
	// segments 1..15 mirror program segments, whole offset range, reads only
	wire d_mirror = !seg0 && (dseg <= SMMD_SEG_MIR_LAST) && !data_write;
	wire d_dflash = (dseg == SMMD_SEG_DFLASH);
	wire [2:0] mir_seg = dseg[2:0];
	wire [19:0] next_data_prog_addr = d_romwin ? {4'h0, dofs} : {1'b0, mir_seg, dofs};
	wire any_sel = d_romwin | d_ram | d_test | d_sfr | d_mirror | d_dflash;
	wire next_unmapped = data_req && !any_sel;

	smmd_region_t region;
	always_comb begin
		region = SMMD_REG_NONE;
		if (d_romwin) region = SMMD_REG_ROMWIN;
		else if (d_ram) region = SMMD_REG_RAM;
		else if (d_test) region = SMMD_REG_TEST;
		else if (d_sfr) region = SMMD_REG_SFR;
		else if (d_mirror) region = SMMD_REG_MIRROR;
		else if (d_dflash) region = SMMD_REG_DFLASH;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			prog_addr <= 20'h00000;
			prog_fetch_en <= 1'b0;
			vector_table_hit <= 1'b0;
			option_region_hit <= 1'b0;
			data_addr <= 21'h000000;
			data_prog_addr <= 20'h00000;
			data_byte_en <= 1'b0;
			sel_ram <= 1'b0;
			sel_special_function_register <= 1'b0;
			sel_romwin <= 1'b0;
			sel_mirror <= 1'b0;
			sel_test <= 1'b0;
			sel_dflash <= 1'b0;
			data_unmapped <= 1'b0;
		end else begin
			prog_addr <= next_prog_addr;
			prog_fetch_en <= next_fetch_en;
			vector_table_hit <= next_vec_hit;
			option_region_hit <= next_copt_hit;
			data_addr <= next_data_addr;
			data_prog_addr <= next_data_prog_addr;
			data_byte_en <= data_req && any_sel;
			sel_ram <= data_req && (region == SMMD_REG_RAM);
			sel_special_function_register <= data_req && (region == SMMD_REG_SFR);
			sel_romwin <= data_req && (region == SMMD_REG_ROMWIN);
			sel_mirror <= data_req && (region == SMMD_REG_MIRROR);
			sel_test <= data_req && (region == SMMD_REG_TEST);
			sel_dflash <= data_req && (region == SMMD_REG_DFLASH);
			data_unmapped <= next_unmapped;
		end
	end

	// ----------------------------------------
	// axi4-lite write channel
	// ----------------------------------------
	logic aw_held;
	logic w_held;
	logic [17:0] aw_addr;
	logic [7:0] w_byte;
	logic w_lane0;
	wire aw_take = s_axi_awvalid && s_axi_awready;
	wire w_take = s_axi_wvalid && s_axi_wready;
	wire have_aw = aw_held || aw_take;
	wire have_w = w_held || w_take;
	wire [17:0] wr_addr = aw_take ? s_axi_awaddr[17:0] : aw_addr;
	wire [7:0] wr_byte = w_take ? s_axi_wdata[7:0] : w_byte;
	wire wr_lane0 = w_take ? s_axi_wstrb[0] : w_lane0;
	wire wr_fire = have_aw && have_w && !s_axi_bvalid;
	wire wr_hit_dseg = wr_addr == {SMMD_OFF_DSEG, 2'b00};
	wire wr_hit_remap = wr_addr == {SMMD_OFF_REMAP, 2'b00};
	wire wr_hit_a4 = wr_addr == {SMMD_OFF_RSVD_A4, 2'b00};
	wire wr_hit_a6 = wr_addr == {SMMD_OFF_RSVD_A6, 2'b00};
	wire wr_hit_cseg = wr_addr == {SMMD_OFF_CSEG, 2'b00};
	wire wr_hit_st = wr_addr == {SMMD_OFF_STATUS, 2'b00};
	wire wr_mapped = wr_hit_dseg | wr_hit_remap | wr_hit_a4 | wr_hit_a6 | wr_hit_cseg | wr_hit_st;
	wire wr_en = wr_fire && wr_lane0;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 18'h00000;
			w_byte <= 8'h00;
			w_lane0 <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= SMMD_RESP_OKAY;
		end else begin
			s_axi_awready <= !have_aw && !s_axi_bvalid;
			s_axi_wready <= !have_w && !s_axi_bvalid;
			if (aw_take) aw_addr <= s_axi_awaddr[17:0];
			if (w_take) begin
				w_byte <= s_axi_wdata[7:0];
				w_lane0 <= s_axi_wstrb[0];
			end
			if (wr_fire) begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_mapped ? SMMD_RESP_OKAY : SMMD_RESP_SLVERR;
			end else begin
				aw_held <= have_aw;
				w_held <= have_w;
				if (s_axi_bvalid && s_axi_bready) s_axi_bvalid <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// register storage
	// ----------------------------------------
	wire st_clr_unm = wr_en && wr_hit_st && wr_byte[SMMD_ST_UNMAPPED];
	wire st_clr_copt = wr_en && wr_hit_st && wr_byte[SMMD_ST_COPT_FETCH];
	wire st_clr_vec = wr_en && wr_hit_st && wr_byte[SMMD_ST_VEC_FETCH];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			data_segment_select <= SMMD_RST_DSEG;
			reserved_slot_a4 <= SMMD_RST_RSVD;
			reserved_slot_a6 <= SMMD_RST_RSVD;
			code_segment_select <= SMMD_RST_CSEG;
			flash_remap_address <= 8'h00;
			remap_loaded <= 1'b0;
			status <= 8'h00;
		end else begin
			// option value captured by the first clocked cycle after release
			if (!remap_loaded) begin
				flash_remap_address <= opt_remap_default;
				remap_loaded <= 1'b1;
			end else if (wr_en && wr_hit_remap) begin
				flash_remap_address <= wr_byte;
			end
			if (wr_en && wr_hit_dseg) data_segment_select <= wr_byte;
			if (wr_en && wr_hit_a4) reserved_slot_a4 <= wr_byte;
			if (wr_en && wr_hit_a6) reserved_slot_a6 <= wr_byte;
			if (wr_en && wr_hit_cseg) code_segment_select <= wr_byte[3:0];
			// sticky flags: a new event wins over a clear
			status[SMMD_ST_UNMAPPED] <= next_unmapped || (status[SMMD_ST_UNMAPPED] && !st_clr_unm);
			status[SMMD_ST_COPT_FETCH] <= next_copt_hit || (status[SMMD_ST_COPT_FETCH] && !st_clr_copt);
			status[SMMD_ST_VEC_FETCH] <= next_vec_hit || (status[SMMD_ST_VEC_FETCH] && !st_clr_vec);
			status[3] <= 1'b0;
			status[SMMD_ST_REGION_LSB +: 3] <= data_req ? region : status[SMMD_ST_REGION_LSB +: 3];
			status[7] <= 1'b0;
		end
	end

	// ----------------------------------------
	// axi4-lite read channel
	// ----------------------------------------
	wire [17:0] rd_addr = s_axi_araddr[17:0];
	wire rd_take = s_axi_arvalid && s_axi_arready;
	wire rd_hit_dseg = rd_addr == {SMMD_OFF_DSEG, 2'b00};
	wire rd_hit_remap = rd_addr == {SMMD_OFF_REMAP, 2'b00};
	wire rd_hit_a4 = rd_addr == {SMMD_OFF_RSVD_A4, 2'b00};
	wire rd_hit_a6 = rd_addr == {SMMD_OFF_RSVD_A6, 2'b00};
	wire rd_hit_cseg = rd_addr == {SMMD_OFF_CSEG, 2'b00};
	wire rd_hit_st = rd_addr == {SMMD_OFF_STATUS, 2'b00};
	wire rd_mapped = rd_hit_dseg | rd_hit_remap | rd_hit_a4 | rd_hit_a6 | rd_hit_cseg | rd_hit_st;
	wire [7:0] rd_byte = rd_hit_dseg ? data_segment_select
		: rd_hit_remap ? flash_remap_address
		: rd_hit_a4 ? reserved_slot_a4
		: rd_hit_a6 ? reserved_slot_a6
		: rd_hit_cseg ? {4'h0, code_segment_select}
		: rd_hit_st ? status
		: 8'h00;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= SMMD_RESP_OKAY;
		end else begin
			s_axi_arready <= !s_axi_rvalid && !rd_take;
			if (rd_take) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= {24'h000000, rd_byte};
				s_axi_rresp <= rd_mapped ? SMMD_RESP_OKAY : SMMD_RESP_SLVERR;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

endmodule

// ===== smmd_decoder_sva.sv
// concurrent checks on the decoder outputs
`timescale 1ns/1ns
module smmd_decoder_sva (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// cpu side
	input wire logic fetch_req,
	input wire logic [15:0] fetch_pc,
	input wire logic data_req,
	input wire logic [15:0] instruction_address_operand,
	// decoded outputs
	input wire logic [19:0] prog_addr,
	input wire logic prog_fetch_en,
	input wire logic option_region_hit,
	input wire logic [20:0] data_addr,
	input wire logic [19:0] data_prog_addr,
	input wire logic data_byte_en,
	input wire logic sel_ram,
	input wire logic sel_special_function_register,
	input wire logic sel_romwin,
	input wire logic sel_mirror,
	input wire logic sel_test,
	input wire logic sel_dflash,
	input wire logic data_unmapped
);
	default clocking @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	a_prog_offset: assert property (fetch_req |=> prog_addr[15:0] == $past(fetch_pc)) else $error("pc bad");
	a_cseg_top: assert property (fetch_req |=> !prog_addr[19]) else $error("cseg top bit used");
	a_data_offset: assert property (data_req |=> data_addr[15:0] == $past(instruction_address_operand))
		else $error("data offset bad");
	a_one_region: assert property (data_req |=> $countones({sel_ram, sel_special_function_register, sel_romwin,
		sel_mirror, sel_test, sel_dflash, data_unmapped}) == 1) else $error("region not one-hot");
	a_byte_enable: assert property (data_req |=> data_byte_en == !data_unmapped) else $error("byte enable bad");
	a_romwin_map: assert property (sel_romwin |-> data_prog_addr == {4'h0, data_addr[15:0]} && data_addr[20:16] == 5'h00)
		else $error("rom window map bad");
	a_mirror_map: assert property (sel_mirror |-> data_prog_addr == {1'b0, data_addr[18:0]} && data_addr[20] == 1'b0)
		else $error("mirror map bad");
	a_dflash_seg: assert property (sel_dflash |-> data_addr[20:16] == 5'h1F) else $error("data flash seg bad");
	a_test_span: assert property (sel_test |-> data_addr[20:10] == 11'h038) else $error("test span bad");
	a_option_fetch: assert property (option_region_hit |-> !prog_fetch_en) else $error("option fetched");
endmodule
bind smmd_decoder smmd_decoder_sva u_sva (.*);

// ===== smmd_decoder_tb_top.sv
// register-level testbench for the decoder
`timescale 1ns/1ns
module smmd_decoder_tb_top;
	import smmd_pkg::*;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] opt_remap_default = 8'h5A;
	logic [17:0] s_axi_awaddr = 18'h00000, s_axi_araddr = 18'h00000;
	logic [15:0] instruction_address_operand, fetch_pc;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, r;
	logic fetch_req, fetch_vector, data_req, data_write, prog_fetch_en, vector_table_hit, option_region_hit;
	logic data_byte_en, sel_ram, sel_special_function_register, sel_romwin, sel_mirror, sel_test, sel_dflash;
	logic data_unmapped;
	logic [19:0] prog_addr, data_prog_addr;
	logic [20:0] data_addr;
	logic [7:0] flash_remap_address;
	int fail_count = 0, samples_checked = 0;
	logic [4:0] ts [11] = '{5'h00, 5'h00, 5'h00, 5'h00, 5'h00, 5'h03, 5'h09, 5'h0F, 5'h1F, 5'h14, 5'h00};
	logic [15:0] tf [11] = '{16'h1234, 16'hD000, 16'hE3FF, 16'hE400, 16'hF000, 16'hFFFF, 16'h0000, 16'h8000,
		16'h0100, 16'h0000, 16'h9000};
	logic [6:0] te [11] = '{7'h04, 7'h01, 7'h10, 7'h40, 7'h02, 7'h08, 7'h08, 7'h08, 7'h20, 7'h40, 7'h40};
	logic [19:0] tp [11] = '{20'h01234, 0, 0, 0, 0, 20'h3FFFF, 20'h10000, 20'h78000, 0, 0, 0};

	always #5 aclk = ~aclk;
	smmd_cpu_model cpu (.*);
	smmd_decoder dut (.*);

	task chk(input logic [31:0] g, input logic [31:0] e);
		samples_checked++;
		if (g !== e) begin
			fail_count++;
			$display("mismatch at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task axw(input logic [15:0] a, input logic [31:0] v, input logic [3:0] st, output logic [1:0] rsp);
		@(posedge aclk);
		s_axi_awaddr <= {a, 2'b00};
		s_axi_wdata <= v;
		s_axi_wstrb <= st;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		rsp = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	task rchk(input logic [15:0] a, input logic [31:0] e, input logic [1:0] er);
		@(posedge aclk);
		s_axi_araddr <= {a, 2'b00};
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		chk(s_axi_rdata, e);
		chk(s_axi_rresp, er);
		s_axi_rready <= 1'b0;
	endtask
	task end_of_test;
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	initial begin
		repeat (5000) @(posedge aclk);
		fail_count++;
		$display("mismatch at %0t: watchdog expired", $time);
		end_of_test;
	end

	initial begin
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		rchk(SMMD_OFF_DSEG, {24'h0, SMMD_RST_DSEG}, SMMD_RESP_OKAY);
		rchk(SMMD_OFF_REMAP, 32'h5A, SMMD_RESP_OKAY);
		rchk(SMMD_OFF_RSVD_A4, {24'h0, SMMD_RST_RSVD}, SMMD_RESP_OKAY);
		rchk(SMMD_OFF_RSVD_A6, {24'h0, SMMD_RST_RSVD}, SMMD_RESP_OKAY);
		axw(SMMD_OFF_DSEG, 32'hFFFFFF1F, 4'hF, r);
		chk(r, SMMD_RESP_OKAY);
		rchk(SMMD_OFF_DSEG, 32'h1F, SMMD_RESP_OKAY);
		axw(SMMD_OFF_DSEG, 32'h02, 4'h0, r);
		rchk(SMMD_OFF_DSEG, 32'h1F, SMMD_RESP_OKAY);
		axw(16'h0010, 32'h01, 4'hF, r);
		chk(r, SMMD_RESP_SLVERR);
		rchk(16'h0010, 32'h0, SMMD_RESP_SLVERR);
		$display("register test done");
		for (int i = 3; i < 16; i += 8) begin
			axw(SMMD_OFF_CSEG, i, 4'hF, r);
			cpu.fetch(16'h1234, 1'b0);
			#1;
			chk(prog_addr, {1'b0, i[2:0], 16'h1234});
			chk(prog_fetch_en, 1'b1);
		end
		axw(SMMD_OFF_CSEG, 32'h0, 4'hF, r);
		cpu.fetch(16'h0004, 1'b1);
		#1;
		chk(vector_table_hit, 1'b1);
		cpu.fetch(16'hFFC0, 1'b0);
		#1;
		chk({option_region_hit, prog_fetch_en}, 2'b10);
		$display("fetch test done");
		for (int i = 0; i < 11; i++) begin
			axw(SMMD_OFF_DSEG, {27'h0, ts[i]}, 4'hF, r);
			cpu.access(tf[i], 1'b0);
			#1;
			chk({data_unmapped, sel_dflash, sel_test, sel_mirror, sel_romwin, sel_special_function_register,
				sel_ram}, te[i]);
			chk(data_addr, {ts[i], tf[i]});
			chk(data_byte_en, !te[i][6]);
			if (te[i][2] || te[i][3]) chk(data_prog_addr, tp[i]);
		end
		cpu.access(16'h1234, 1'b1);
		#1;
		chk(data_unmapped, 1'b1);
		$display("data map test done");
		rchk(SMMD_OFF_STATUS, 32'h07, SMMD_RESP_OKAY);
		axw(SMMD_OFF_STATUS, 32'h07, 4'hF, r);
		rchk(SMMD_OFF_STATUS, 32'h00, SMMD_RESP_OKAY);
		axw(SMMD_OFF_REMAP, 32'hA5, 4'hF, r);
		chk(flash_remap_address, 8'hA5);
		rchk(SMMD_OFF_REMAP, 32'hA5, SMMD_RESP_OKAY);
		axw(SMMD_OFF_RSVD_A4, 32'h3C, 4'hF, r);
		rchk(SMMD_OFF_RSVD_A4, 32'h3C, SMMD_RESP_OKAY);
		$display("status test done");
		end_of_test;
	end
endmodule

// ===== smmd_pkg.sv
// package of constants for the segmented memory map decoder
package smmd_pkg;

	// ----------------------------------------
	// register indices; the bus byte address is four times the index
	// ----------------------------------------
	localparam logic [15:0] SMMD_OFF_DSEG = 16'hF000;
	localparam logic [15:0] SMMD_OFF_REMAP = 16'hF0A0;
	localparam logic [15:0] SMMD_OFF_RSVD_A4 = 16'hF0A4;
	localparam logic [15:0] SMMD_OFF_RSVD_A6 = 16'hF0A6;
	localparam logic [15:0] SMMD_OFF_CSEG = 16'hF0B0;
	localparam logic [15:0] SMMD_OFF_STATUS = 16'hF0B4;

	// ----------------------------------------
	// reset values
	// ----------------------------------------
	localparam logic [7:0] SMMD_RST_DSEG = 8'h00;
	localparam logic [7:0] SMMD_RST_RSVD = 8'h00;
	localparam logic [3:0] SMMD_RST_CSEG = 4'h0;

	// ----------------------------------------
	// address widths and segment figures
	// ----------------------------------------
	localparam int SMMD_OFS_W = 16;
	localparam int SMMD_CSEG_W = 4;
	localparam int SMMD_DSEG_W = 5;
	localparam int SMMD_PADDR_W = 20;
	localparam int SMMD_DADDR_W = 21;
	localparam logic [4:0] SMMD_SEG_ZERO = 5'h00;
	localparam logic [4:0] SMMD_SEG_MIR_LAST = 5'h0F;
	localparam logic [4:0] SMMD_SEG_DFLASH = 5'h1F;

	// ----------------------------------------
	// segment 0 data-space layout (offsets within segment)
	// ----------------------------------------
	localparam logic [15:0] SMMD_ROMWIN_LAST = 16'h7FFF;
	localparam logic [15:0] SMMD_RAM_FIRST = 16'hD000;
	localparam logic [15:0] SMMD_RAM_LAST = 16'hDFFF;
	localparam logic [15:0] SMMD_TEST_FIRST = 16'hE000;
	localparam logic [15:0] SMMD_TEST_LAST = 16'hE3FF;
	localparam logic [15:0] SMMD_SFR_FIRST = 16'hF000;
	localparam logic [15:0] SMMD_SFR_LAST = 16'hFFFF;

	// ----------------------------------------
	// program-space regions
	// ----------------------------------------
	localparam logic [19:0] SMMD_VEC_LAST = 20'h000FF;
	localparam logic [19:0] SMMD_COPT_FIRST = 20'h0FFC0;
	localparam logic [19:0] SMMD_COPT_LAST = 20'h0FFFF;

	// ----------------------------------------
	// region codes and status bits
	// ----------------------------------------
	typedef enum logic [2:0] {
		SMMD_REG_NONE,
		SMMD_REG_RAM,
		SMMD_REG_SFR,
		SMMD_REG_ROMWIN,
		SMMD_REG_MIRROR,
		SMMD_REG_TEST,
		SMMD_REG_DFLASH
	} smmd_region_t;
	localparam int SMMD_ST_UNMAPPED = 0;
	localparam int SMMD_ST_COPT_FETCH = 1;
	localparam int SMMD_ST_VEC_FETCH = 2;
	localparam int SMMD_ST_REGION_LSB = 4;
	localparam logic [1:0] SMMD_RESP_OKAY = 2'b00;
	localparam logic [1:0] SMMD_RESP_SLVERR = 2'b10;

endpackage
